// ---- bcs_cmd_status.v ----
// Purpose : upper command bits and status register of a switch port's type-1 bridge
// Assumes : one 20 MHz clock; config requests decoded to a plain register port
// Notes   : lower command bits other than poison enable, identification registers and hot-plug controller live elsewhere
`timescale 1ns/100ps
`include "bcs_regs_map.vh"

// Functional notes
// - interrupt disable set negates the bridge's own interrupt; read/write, resets to zero
// - interrupt disable never touches interrupts forwarded from secondary to primary
// - pending status bit reads one while the bridge's own interrupt is pending
// - forwarded emulated interrupts from devices below never show in pending bit
// - downstream port: pending bit set while hot-plug controller asserts its interrupt
// - upstream port: pending bit always reads zero
// - capability list present bit is hardwired to one
// - master poison flag sets on poisoned completion or poisoned write, if enabled
// - system error flag sets when fatal/non-fatal message sent with reporting enabled
// - poison detected flag sets on any poisoned TLP received, regardless of enable
// - the three error flags are sticky, reset zero, cleared by writing one
// - unused command and status bits read zero and ignore writes
// - poison reporting enable clear means master poison flag never sets
// - reporting enable gates forwarding of fatal/non-fatal; correctable always forwarded
module bcs_cmd_status
(
  // clock and reset
  input  wire                    clk,
  input  wire                    rst_n,
  // register port
  input  wire [`BCS_ADDR_W-1:0]  reg_addr,
  input  wire [`BCS_REG_W-1:0]   reg_wdata,
  input  wire [1:0]              reg_wr_be,
  input  wire                    reg_wr,
  input  wire                    reg_rd,
  output wire [`BCS_REG_W-1:0]   reg_rdata,
  // port role strap pin
  input  wire                    upstream_port_pin,
  // own interrupt source
  input  wire                    hp_irq_asserted,
  output wire                    legacy_irq_out,
  // forwarded interrupt
  input  wire                    sec_intx_in,
  output wire                    pri_intx_fwd_out,
  // primary side poison events
  input  wire                    rx_poison_cpl,
  input  wire                    tx_poison_wr,
  input  wire                    rx_poison_tlp,
  // own error message sent
  input  wire                    own_err_msg_sent,
  // secondary error messages
  input  wire                    sec_err_cor,
  input  wire                    sec_err_nonfatal,
  input  wire                    sec_err_fatal,
  output wire                    pri_err_cor_out,
  output wire                    pri_err_nonfatal_out,
  output wire                    pri_err_fatal_out,
  // enables seen by the rest of the port
  output wire                    poison_report_enable_out,
  output wire                    error_report_enable_out,
  // interrupt
  output wire                    irq_out
);

  // ****************************************
  // declarations
  // ****************************************
  reg                    poison_report_enable_reg;
  reg                    error_report_enable_reg;
  reg                    legacy_irq_disable_reg;
  reg  [`BCS_IRQ_N-1:0]  irq_mask_reg;
  reg  [`BCS_REG_W-1:0]  rdata_reg;
  reg  [`BCS_REG_W-1:0]  rdata_next;
  reg                    legacy_irq_reg;
  reg                    fwd_intx_reg;
  reg                    fwd_cor_reg;
  reg                    fwd_nonfatal_reg;
  reg                    fwd_fatal_reg;
  reg                    irq_reg;
  reg                    is_upstream_reg;
  reg                    strap_done_reg;
  reg                    pending_prev_reg;

  wire                   upstream_sync;
  wire                   wr_cmd;
  wire                   wr_sts;
  wire                   wr_mask;
  wire                   rd_irq_sts;
  wire                   legacy_pending;
  wire                   fwd_fatal_now;
  wire                   err_sent_now;
  wire [2:0]             err_set;
  wire [2:0]             err_clr;
  wire [2:0]             err_q;
  wire [`BCS_IRQ_N-1:0]  irq_set;
  wire [`BCS_IRQ_N-1:0]  irq_q;
  wire [`BCS_REG_W-1:0]  cmd_view;
  wire [`BCS_REG_W-1:0]  sts_view;
  wire                   role_known;
  wire                   sts_clr_lane;
  wire                   irq_any;

  // ****************************************
  // port role strap
  // ****************************************
  bcs_sync2 u_strap_sync
  (
    .clk   (clk),
    .rst_n (rst_n),
    .d_in  (upstream_port_pin),
    .q_out (upstream_sync)
  );

  // caught once after release, the synchroniser needs two edges to settle
  reg [1:0] strap_wait_reg;

  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      strap_wait_reg  <= `BCS_STRAP_INIT;
      strap_done_reg  <= `BCS_RST_BIT;
      is_upstream_reg <= `BCS_RST_BIT;
    end
    else if (!strap_done_reg)
    begin
      strap_wait_reg <= strap_wait_reg + `BCS_STRAP_STEP;
      if (strap_wait_reg == `BCS_STRAP_LAST)
      begin
        is_upstream_reg <= upstream_sync;
        strap_done_reg  <= 1'b1;
      end
    end
  end

  // ****************************************
  // address decode
  // ****************************************
  assign wr_cmd     = reg_wr & (reg_addr == `BCS_ADDR_CMD);
  assign wr_sts     = reg_wr & (reg_addr == `BCS_ADDR_STS);
  assign wr_mask    = reg_wr & (reg_addr == `BCS_ADDR_IRQ_MASK);
  assign rd_irq_sts = reg_rd & (reg_addr == `BCS_ADDR_IRQ_STS);

  // ****************************************
  // command bits
  // ****************************************
  // lower command byte holds only the poison enable in this block
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      poison_report_enable_reg <= `BCS_RST_BIT;
      error_report_enable_reg  <= `BCS_RST_BIT;
      legacy_irq_disable_reg   <= `BCS_RST_BIT;
    end
    else if (wr_cmd)
    begin
      if (reg_wr_be[0])
        poison_report_enable_reg <= reg_wdata[`BCS_CMD_PERR_BIT];
      if (reg_wr_be[1])
      begin
        error_report_enable_reg <= reg_wdata[`BCS_CMD_SERR_BIT];
        legacy_irq_disable_reg  <= reg_wdata[`BCS_CMD_IRQ_DIS_BIT];
      end
    end
  end

  // ****************************************
  // own interrupt
  // ****************************************
  // hot-plug only counts on a downstream port
  // role unknown until the strap is latched: no pending bit in either role
  assign role_known     = strap_done_reg;
  assign legacy_pending = hp_irq_asserted & role_known & ~is_upstream_reg;

  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      legacy_irq_reg <= `BCS_RST_BIT;
      fwd_intx_reg   <= `BCS_RST_BIT;
    end
    else
    begin
      legacy_irq_reg <= legacy_pending & ~legacy_irq_disable_reg;
      fwd_intx_reg   <= sec_intx_in;
    end
  end

  // ****************************************
  // error message forwarding
  // ****************************************
  assign fwd_fatal_now = error_report_enable_reg & (sec_err_nonfatal | sec_err_fatal);

  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      fwd_cor_reg      <= `BCS_RST_BIT;
      fwd_nonfatal_reg <= `BCS_RST_BIT;
      fwd_fatal_reg    <= `BCS_RST_BIT;
    end
    else
    begin
      fwd_cor_reg      <= sec_err_cor;
      fwd_nonfatal_reg <= sec_err_nonfatal & error_report_enable_reg;
      fwd_fatal_reg    <= sec_err_fatal & error_report_enable_reg;
    end
  end

  // forwarded messages are sent by this bridge too
  assign err_sent_now = error_report_enable_reg & (own_err_msg_sent | fwd_fatal_now);

  // ****************************************
  // sticky error flags
  // ****************************************
  assign err_set[0] = poison_report_enable_reg & (rx_poison_cpl | tx_poison_wr);
  assign err_set[1] = err_sent_now;
  assign err_set[2] = rx_poison_tlp;

  // all three flags sit in the upper byte lane
  assign sts_clr_lane = wr_sts & reg_wr_be[1];

  assign err_clr[0] = sts_clr_lane & reg_wdata[`BCS_STS_MPOISON_BIT];
  assign err_clr[1] = sts_clr_lane & reg_wdata[`BCS_STS_SYSERR_BIT];
  assign err_clr[2] = sts_clr_lane & reg_wdata[`BCS_STS_POISON_BIT];

  genvar gi;
  generate
    for (gi = 0; gi < `BCS_ERR_N; gi = gi + 1)
    begin : g_err
      bcs_flag u_flag
      (
        .clk    (clk),
        .rst_n  (rst_n),
        .set_in (err_set[gi]),
        .clr_in (err_clr[gi]),
        .q_out  (err_q[gi])
      );
    end
  endgenerate

  // ****************************************
  // interrupt status and mask
  // ****************************************
  always @(posedge clk)
  begin
    if (!rst_n)
      pending_prev_reg <= `BCS_RST_BIT;
    else
      pending_prev_reg <= legacy_pending;
  end

  // a read clears the status, a set in the same cycle still lands
  assign irq_set[`BCS_IRQ_MPOISON] = err_set[0];
  assign irq_set[`BCS_IRQ_SYSERR]  = err_set[1];
  assign irq_set[`BCS_IRQ_POISON]  = err_set[2];
  assign irq_set[`BCS_IRQ_PEND]    = legacy_pending & ~pending_prev_reg;

  generate
    for (gi = 0; gi < `BCS_IRQ_N; gi = gi + 1)
    begin : g_irq
      bcs_flag u_flag
      (
        .clk    (clk),
        .rst_n  (rst_n),
        .set_in (irq_set[gi]),
        .clr_in (rd_irq_sts),
        .q_out  (irq_q[gi])
      );
    end
  endgenerate

  always @(posedge clk)
  begin
    if (!rst_n)
      irq_mask_reg <= `BCS_ZERO4;
    else if (wr_mask & reg_wr_be[0])
      irq_mask_reg <= reg_wdata[`BCS_IRQ_N-1:0];
  end

  assign irq_any = |(irq_q & irq_mask_reg);

  always @(posedge clk)
  begin
    if (!rst_n)
      irq_reg <= `BCS_RST_BIT;
    else
      irq_reg <= irq_any;
  end

  // ****************************************
  // read views
  // ****************************************
  // unnamed bits are constant zero, writes to them go nowhere
  assign cmd_view = {5'h00,
                     legacy_irq_disable_reg,
                     1'b0,
                     error_report_enable_reg,
                     1'b0,
                     poison_report_enable_reg,
                     6'h00};

  assign sts_view = {err_q[2],
                     err_q[1],
                     5'h00,
                     err_q[0],
                     3'h0,
                     `BCS_CAP_VAL,
                     legacy_pending,
                     3'h0};

  always @*
  begin
    rdata_next = `BCS_ZERO16;
    if (reg_rd)
    begin
      case (reg_addr)
        `BCS_ADDR_CMD:      rdata_next = cmd_view;
        `BCS_ADDR_STS:      rdata_next = sts_view;
        `BCS_ADDR_IRQ_STS:  rdata_next = {12'h000, irq_q};
        `BCS_ADDR_IRQ_MASK: rdata_next = {12'h000, irq_mask_reg};
        default:            rdata_next = `BCS_ZERO16;
      endcase
    end
  end

  always @(posedge clk)
  begin
    if (!rst_n)
      rdata_reg <= `BCS_ZERO16;
    else
      rdata_reg <= rdata_next;
  end

  // ****************************************
  // outputs
  // ****************************************
  assign reg_rdata                = rdata_reg;
  assign legacy_irq_out           = legacy_irq_reg;
  assign pri_intx_fwd_out         = fwd_intx_reg;
  assign pri_err_cor_out          = fwd_cor_reg;
  assign pri_err_nonfatal_out     = fwd_nonfatal_reg;
  assign pri_err_fatal_out        = fwd_fatal_reg;
  assign poison_report_enable_out = poison_report_enable_reg;
  assign error_report_enable_out  = error_report_enable_reg;
  assign irq_out                  = irq_reg;

endmodule // bcs_cmd_status

// ---- bcs_regs_map.vh ----
// Purpose : address map, field positions and reset values of the bridge command/status block
// Assumes : included by every bcs design file by its bare name
// Notes   : definitions only
`ifndef BCS_REGS_MAP_VH
`define BCS_REGS_MAP_VH

// ****************************************
// addresses
// ****************************************
`define BCS_ADDR_W          12
`define BCS_ADDR_CMD        12'h0004
`define BCS_ADDR_STS        12'h0006
`define BCS_ADDR_IRQ_STS    12'h0100
`define BCS_ADDR_IRQ_MASK   12'h0104

// ****************************************
// command fields
// ****************************************
`define BCS_CMD_PERR_BIT    6
`define BCS_CMD_SERR_BIT    8
`define BCS_CMD_FAST_B2B_BIT 9
`define BCS_CMD_IRQ_DIS_BIT 10

// ****************************************
// status fields
// ****************************************
`define BCS_STS_PEND_BIT    3
`define BCS_STS_CAP_BIT     4
`define BCS_STS_MPOISON_BIT 8
`define BCS_STS_SYSERR_BIT  14
`define BCS_STS_POISON_BIT  15

// ****************************************
// interrupt status layout
// ****************************************
`define BCS_IRQ_N           4
`define BCS_IRQ_MPOISON     0
`define BCS_IRQ_SYSERR      1
`define BCS_IRQ_POISON      2
`define BCS_IRQ_PEND        3
`define BCS_ERR_N           3

// ****************************************
// widths and reset values
// ****************************************
`define BCS_REG_W           16
`define BCS_ZERO16          16'h0000
`define BCS_ZERO4           4'h0
`define BCS_RST_BIT         1'b0
`define BCS_CAP_VAL         1'b1

// ****************************************
// strap capture timing
// ****************************************
`define BCS_STRAP_INIT      2'h0
`define BCS_STRAP_STEP      2'h1
`define BCS_STRAP_LAST      2'h2

`endif

// ---- bcs_sync2.v ----
// Purpose : two-stage synchroniser for a level from outside the clock domain
// Assumes : clk domain, synchronous active-low reset
// Notes   : first stage feeds only the second
`timescale 1ns/100ps
`include "bcs_regs_map.vh"

module bcs_sync2
(
  // clock and reset
  input  wire clk,
  input  wire rst_n,
  // level
  input  wire d_in,
  output wire q_out
);

  reg meta_reg;
  reg sync_reg;

  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      meta_reg <= `BCS_RST_BIT;
      sync_reg <= `BCS_RST_BIT;
    end
    else
    begin
      meta_reg <= d_in;
      sync_reg <= meta_reg;
    end
  end

  assign q_out = sync_reg;

endmodule // bcs_sync2

// ---- bcs_flag.v ----
// Purpose : sticky status flag, hardware sets, software clears
// Assumes : clk domain, synchronous active-low reset
// Notes   : a set in the clearing cycle wins
`timescale 1ns/100ps
`include "bcs_regs_map.vh"

module bcs_flag
(
  // clock and reset
  input  wire clk,
  input  wire rst_n,
  // control
  input  wire set_in,
  input  wire clr_in,
  output wire q_out
);

  reg flag_reg;
  reg flag_next;

  always @*
  begin
    flag_next = flag_reg;
    if (clr_in)
      flag_next = 1'b0;
    if (set_in)
      flag_next = 1'b1;
  end

  always @(posedge clk)
  begin
    if (!rst_n)
      flag_reg <= `BCS_RST_BIT;
    else
      flag_reg <= flag_next;
  end

  assign q_out = flag_reg;

endmodule // bcs_flag

// ---- bcs_cmd_status_monitor.sv ----
// Purpose : concurrent checks on the command/status block ports
// Assumes : one clock, synchronous active-low reset
// Notes   : bound to every bcs_cmd_status instance
`timescale 1ns/100ps
module bcs_cmd_status_monitor
(
  // clock and reset
  input wire        clk,
  input wire        rst_n,
  // register port
  input wire [11:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire [1:0]  reg_wr_be,
  input wire        reg_wr,
  input wire        reg_rd,
  input wire [15:0] reg_rdata,
  // interrupts and forwarding
  input wire        hp_irq_asserted,
  input wire        legacy_irq_out,
  input wire        sec_intx_in,
  input wire        pri_intx_fwd_out,
  input wire        sec_err_cor,
  input wire        sec_err_nonfatal,
  input wire        sec_err_fatal,
  input wire        pri_err_cor_out,
  input wire        pri_err_nonfatal_out,
  input wire        pri_err_fatal_out,
  input wire        error_report_enable_out
);
  // ****************
  // checks
  // ****************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_intx_fwd_free: assert property ($past(rst_n) |-> pri_intx_fwd_out == $past(sec_intx_in))
    else $error("forwarded interrupt wrong");
  a_cor_always_fwd: assert property ($past(rst_n) |-> pri_err_cor_out == $past(sec_err_cor))
    else $error("correctable message not forwarded");
  a_fatal_gated: assert property (sec_err_fatal && !error_report_enable_out |=> !pri_err_fatal_out)
    else $error("fatal forwarded while disabled");
  a_nonfatal_fwd: assert property (sec_err_nonfatal && error_report_enable_out |=> pri_err_nonfatal_out)
    else $error("nonfatal not forwarded");
  a_fatal_fwd: assert property (sec_err_fatal && error_report_enable_out |=> pri_err_fatal_out)
    else $error("fatal not forwarded");
  a_nonfatal_gated: assert property (sec_err_nonfatal && !error_report_enable_out |=> !pri_err_nonfatal_out)
    else $error("nonfatal forwarded while disabled");
  a_irq_disable_off:
    assert property (reg_wr && reg_addr == 12'h004 && reg_wr_be[1] && reg_wdata[10]
      |-> ##2 !legacy_irq_out [*2]) else $error("own interrupt not negated");
  a_own_irq_cause: assert property ($past(rst_n) && legacy_irq_out |-> $past(hp_irq_asserted))
    else $error("own interrupt without source");
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 16'h0000)
    else $error("read data outside read cycle");
  a_sts_fixed_bits:
    assert property (reg_rd && reg_addr == 12'h006 |=> reg_rdata[4] && (reg_rdata & 16'h3EE7) == 16'h0000)
      else $error("status constant bits wrong");
  a_cmd_fixed_bits:
    assert property (reg_rd && reg_addr == 12'h004 |=> (reg_rdata & 16'hFABF) == 16'h0000)
      else $error("command constant bits wrong");
endmodule // bcs_cmd_status_monitor

bind bcs_cmd_status bcs_cmd_status_monitor u_mon (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr_be(reg_wr_be), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .hp_irq_asserted(hp_irq_asserted), .legacy_irq_out(legacy_irq_out),
  .sec_intx_in(sec_intx_in), .pri_intx_fwd_out(pri_intx_fwd_out), .sec_err_cor(sec_err_cor),
  .sec_err_nonfatal(sec_err_nonfatal), .sec_err_fatal(sec_err_fatal),
  .pri_err_cor_out(pri_err_cor_out), .pri_err_nonfatal_out(pri_err_nonfatal_out),
  .pri_err_fatal_out(pri_err_fatal_out), .error_report_enable_out(error_report_enable_out));

// ---- bcs_rc_model.sv ----
// Purpose : root complex model issuing config reads and writes
// Assumes : strobes change just after the rising edge
// Notes   : idle bus shows the inverse of the last value, never a stale copy
`timescale 1ns/100ps
module bcs_rc_model
(
  // clock
  input  wire        clk,
  // register port
  output reg  [11:0] reg_addr,
  output reg  [15:0] reg_wdata,
  output reg  [1:0]  reg_wr_be,
  output reg         reg_wr,
  output reg         reg_rd,
  input  wire [15:0] reg_rdata
);
  initial
  begin
    reg_addr = 12'h0000;
    reg_wdata = 16'h0000;
    reg_wr_be = 2'b00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // 16-bit write, lanes by byte enable, a one clears a sticky flag
  task wr(input [11:0] a, input [1:0] be, input [15:0] d);
  begin
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr_be <= be;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
    reg_wr_be <= ~be;
  end
  endtask
  // data taken mid-cycle after the strobe, where it alone stands
  task rd(input [11:0] a, output [15:0] d);
  begin
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    @(negedge clk);
    d = reg_rdata;
  end
  endtask
endmodule // bcs_rc_model

// ---- tb_bridge_cmd_status_regs.sv ----
// Purpose : directed register and event tests of the command/status block
// Assumes : 20 MHz clock, strap read as downstream after first reset
// Notes   : second reset switches to upstream role
`timescale 1ns/100ps
module tb_bridge_cmd_status_regs;
  reg         clk;
  reg         rst_n;
  reg         upstream_port_pin;
  reg         hp_irq_asserted;
  reg         sec_intx_in;
  reg  [6:0]  ev;
  wire [11:0] reg_addr;
  wire [15:0] reg_wdata;
  wire [1:0]  reg_wr_be;
  wire        reg_wr;
  wire        reg_rd;
  wire [15:0] reg_rdata;
  wire [4:0]  outs;
  reg  [15:0] rv;
  integer     err_total;
  integer     checks_done;
  integer     cyc;

  bcs_rc_model m (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr_be(reg_wr_be),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  bcs_cmd_status dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr_be(reg_wr_be), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .upstream_port_pin(upstream_port_pin), .hp_irq_asserted(hp_irq_asserted),
    .legacy_irq_out(outs[2]), .sec_intx_in(sec_intx_in), .pri_intx_fwd_out(outs[1]),
    .rx_poison_cpl(ev[1]), .tx_poison_wr(ev[2]), .rx_poison_tlp(ev[0]), .own_err_msg_sent(ev[3]),
    .sec_err_cor(ev[4]), .sec_err_nonfatal(ev[5]), .sec_err_fatal(ev[6]), .pri_err_cor_out(),
    .pri_err_nonfatal_out(), .pri_err_fatal_out(), .poison_report_enable_out(outs[3]),
    .error_report_enable_out(outs[4]), .irq_out(outs[0]));

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // hang guard, the run needs well under a thousand cycles
  always @(posedge clk)
  begin
    cyc = cyc + 1;
    if (cyc == 3000)
    begin
      err_total = err_total + 1;
      wrap_up;
    end
  end

  task wrap_up;
  begin
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  end
  endtask
  task chk(input [15:0] seen, input [15:0] exp);
  begin
    checks_done = checks_done + 1;
    if (seen !== exp)
    begin
      err_total = err_total + 1;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  end
  endtask
  task rc(input [11:0] a, input [15:0] exp);
  begin
    m.rd(a, rv);
    chk(rv, exp);
  end
  endtask
  // settles first so a level output is judged after its delay of up to two cycles
  task bc(input integer i, input e);
  begin
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk({15'h0000, outs[i]}, {15'h0000, e});
  end
  endtask
  task pulse(input [6:0] v);
  begin
    @(posedge clk);
    ev <= v;
    @(posedge clk);
    ev <= 7'h00;
  end
  endtask

  initial
  begin
    err_total = 0;
    checks_done = 0;
    cyc = 0;
    rst_n = 1'b0;
    upstream_port_pin = 1'b0;
    hp_irq_asserted = 1'b0;
    sec_intx_in = 1'b0;
    ev = 7'h00;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (5) @(posedge clk);
    rc(12'h004, 16'h0000);
    rc(12'h006, 16'h0010);
    rc(12'h104, 16'h0000);
    rc(12'h008, 16'h0000);
    m.wr(12'h004, 2'b11, 16'hFFFF);
    rc(12'h004, 16'h0540);
    bc(3, 1'b1);
    bc(4, 1'b1);
    m.wr(12'h004, 2'b01, 16'h0000);
    rc(12'h004, 16'h0500);
    bc(3, 1'b0);
    m.wr(12'h004, 2'b11, 16'h0000);
    m.wr(12'h006, 2'b11, 16'hFFFF);
    rc(12'h006, 16'h0010);
    pulse(7'h06);
    rc(12'h006, 16'h0010);
    pulse(7'h01);
    rc(12'h006, 16'h8010);
    m.wr(12'h004, 2'b11, 16'h0140);
    pulse(7'h02);
    rc(12'h006, 16'h8110);
    m.wr(12'h006, 2'b10, 16'h0100);
    rc(12'h006, 16'h8010);
    m.wr(12'h006, 2'b11, 16'h0000);
    rc(12'h006, 16'h8010);
    pulse(7'h04);
    rc(12'h006, 16'h8110);
    m.wr(12'h006, 2'b01, 16'hFFFF);
    rc(12'h006, 16'h8110);
    pulse(7'h08);
    pulse(7'h70);
    rc(12'h006, 16'hC110);
    m.wr(12'h006, 2'b10, 16'hC100);
    rc(12'h006, 16'h0010);
    m.wr(12'h004, 2'b11, 16'h0000);
    pulse(7'h78);
    rc(12'h006, 16'h0010);
    rc(12'h100, 16'h0007);
    rc(12'h100, 16'h0000);
    m.wr(12'h104, 2'b11, 16'h0004);
    pulse(7'h01);
    bc(0, 1'b1);
    rc(12'h100, 16'h0004);
    bc(0, 1'b0);
    m.wr(12'h104, 2'b11, 16'h000B);
    pulse(7'h01);
    bc(0, 1'b0);
    rc(12'h100, 16'h0004);
    m.wr(12'h006, 2'b10, 16'h8000);
    @(posedge clk) sec_intx_in <= 1'b1;
    bc(1, 1'b1);
    rc(12'h006, 16'h0010);
    @(posedge clk) hp_irq_asserted <= 1'b1;
    bc(2, 1'b1);
    bc(0, 1'b1);
    rc(12'h006, 16'h0018);
    rc(12'h100, 16'h0008);
    m.wr(12'h004, 2'b10, 16'h0400);
    bc(2, 1'b0);
    bc(1, 1'b1);
    @(posedge clk) rst_n <= 1'b0;
    upstream_port_pin <= 1'b1;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (5) @(posedge clk);
    rc(12'h006, 16'h0010);
    bc(2, 1'b0);
    wrap_up;
  end
endmodule // tb_bridge_cmd_status_regs
